// ===== tb.sv
// self-checking bench for the timer channel
`timescale 1ns/1ps
`include "timer_defines.svh"
module tb;
  logic CLK, RST, HSEL, HWRITE, go, pin, OUT, OE, IRQ, busy, last_out, HREADYOUT, HRESP;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, hold;
  logic [7:0] n_edge, half;
  int errors, n_tests, n_irq, n_tog, cyc, last_irq, gap;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} row_t;
  row_t rows [6] = '{
    '{`OFS_RELOAD_VALUE, 32'h0001FFFF, 32'h0000FFFF},
    '{`OFS_STOP_TRIGGER, 32'h1, 32'h0},
    '{`OFS_COUNTER, 32'h5, 32'h0},
    '{8'h40, 32'h7, 32'h0},
    '{`OFS_PRESCALER_SEL, 32'h1FF, 32'hFF},
    '{`OFS_PRESCALER_SEL, 32'h0, 32'h0}};

  timer_channel u_timer_channel (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CHAN0_INPUT_PIN(pin),
    .CHAN0_OUTPUT_PIN(OUT), .CHAN0_OUTPUT_OE(OE), .CHAN_INTERRUPT(IRQ));
  timer_edge_source u_timer_edge_source (.CLK(CLK), .RST(RST), .go(go), .n_edge(n_edge),
    .half(half), .pin(pin), .busy(busy));

  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // counted at the falling edge, where registered outputs have settled
  always @(negedge CLK) begin
    cyc = cyc + 1;
    if (IRQ === 1'b1) begin
      n_irq = n_irq + 1;
      gap = cyc - last_irq;
      last_irq = cyc;
    end
    if (OUT !== last_out) n_tog = n_tog + 1;
    last_out = OUT;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h000000, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  task automatic settle;
    repeat (2) @(posedge CLK);
    #1;
  endtask

  task automatic wait_irq(input int k);
    int t;
    t = n_irq + k;
    repeat (200) if (n_irq < t) @(posedge CLK);
    #1;
  endtask

  task automatic pulse(input logic [7:0] n, input logic [7:0] h);
    @(posedge CLK);
    n_edge <= n;
    half <= h;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    #1;
    repeat (300) if (busy === 1'b1) @(posedge CLK);
    repeat (12) @(posedge CLK);
    #1;
  endtask

  task automatic test_done;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    $display("watchdog expired");
    test_done;
  end

  initial begin
    RST = 1'b1;
    HSEL = 1'b0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HADDR = 32'h0;
    HWDATA = 32'h0;
    go = 1'b0;
    n_edge = 8'h00;
    half = 8'h00;
    last_out = 1'b0;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    settle;
    chk("oe_reset", 32'(OE), 32'h0);
    bus(1'b1, `OFS_RELOAD_VALUE, 32'h5);
    rdchk(`OFS_RELOAD_VALUE, 32'h0, "write_off");
    bus(1'b1, `OFS_UNIT_ENABLE, 32'h1);
    settle;
    chk("oe_on", 32'(OE), 32'h1);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e, "reg_row");
    end
    $display("test registers done");
    bus(1'b1, `OFS_OUTPUT_VALUE, 32'h1);
    settle;
    chk("pin_hi", 32'(OUT), 32'h1);
    bus(1'b1, `OFS_OUTPUT_VALUE, 32'h0);
    settle;
    chk("pin_lo", 32'(OUT), 32'h0);
    $display("test output value done");
    bus(1'b1, `OFS_RELOAD_VALUE, 32'h2);
    bus(1'b1, `OFS_MODE_CONFIG, 32'h1); // output mode and level left at 0
    bus(1'b1, `OFS_OUTPUT_ENABLE, 32'h1);
    n_irq = 0;
    bus(1'b1, `OFS_START_TRIGGER, 32'h1);
    repeat (4) @(posedge CLK);
    #1;
    chk("start_irq", 32'(n_irq), 32'h1);
    rdchk(`OFS_ENABLE_STATUS, 32'h1, "running");
    rdchk(`OFS_START_TRIGGER, 32'h0, "start_clr");
    n_tog = 0;
    wait_irq(2);
    chk("period", 32'(gap), 32'h3);
    chk("toggles", 32'(n_tog), 32'h2);
    bus(1'b1, `OFS_RELOAD_VALUE, 32'h5); // reload may change while running
    wait_irq(1);
    chk("old_period", 32'(gap), 32'h3);
    wait_irq(1);
    chk("new_period", 32'(gap), 32'h6);
    bus(1'b1, `OFS_STOP_TRIGGER, 32'h1);
    settle;
    n_tog = 0;
    bus(1'b0, `OFS_COUNTER, 32'h0);
    hold = rd;
    repeat (10) @(posedge CLK);
    rdchk(`OFS_COUNTER, hold, "held");
    rdchk(`OFS_ENABLE_STATUS, 32'h0, "stopped");
    chk("no_reinit", 32'(n_tog), 32'h0);
    bus(1'b1, `OFS_OUTPUT_VALUE, {31'h00000000, ~OUT}); // enabled output refuses writes
    settle;
    chk("val_locked", 32'(n_tog), 32'h0);
    $display("test interval done");
    bus(1'b1, `OFS_OUTPUT_ENABLE, 32'h0);
    bus(1'b1, `OFS_OUTPUT_VALUE, 32'h1);
    bus(1'b1, `OFS_START_TRIGGER, 32'h1);
    settle;
    n_tog = 0;
    wait_irq(3);
    chk("gated", 32'(n_tog), 32'h0);
    chk("gated_lvl", 32'(OUT), 32'h1);
    bus(1'b1, `OFS_STOP_TRIGGER, 32'h1);
    bus(1'b1, `OFS_PRESCALER_SEL, 32'h10);
    bus(1'b1, `OFS_MODE_CONFIG, 32'h8001);
    bus(1'b1, `OFS_START_TRIGGER, 32'h1);
    wait_irq(3);
    chk("ck1_period", 32'(gap), 32'hC);
    bus(1'b1, `OFS_STOP_TRIGGER, 32'h1);
    $display("test gating and clock select done");
    bus(1'b1, `OFS_PRESCALER_SEL, 32'h0);
    bus(1'b1, `OFS_OUTPUT_ENABLE, 32'h0); // cleared before event counting
    bus(1'b1, `OFS_RELOAD_VALUE, 32'h3);
    for (int c = 0; c < 4; c++) begin // code 3 is the prohibited edge select: counts nothing
      bus(1'b1, `OFS_MODE_CONFIG, 32'h6 | 32'(c << 6));
      bus(1'b1, `OFS_START_TRIGGER, 32'h1);
      repeat (4) @(posedge CLK);
      rdchk(`OFS_COUNTER, 32'h3, "ev_load");
      n_irq = 0;
      pulse(8'h08, 8'(3 + 2 * c));
      chk("ev_irq", 32'(n_irq), 32'(c == 2) + 32'(c != 3));
      bus(1'b1, `OFS_STOP_TRIGGER, 32'h1);
    end
    bus(1'b1, `OFS_NOISE_FILTER, 32'h1);
    bus(1'b1, `OFS_MODE_CONFIG, 32'h46);
    bus(1'b1, `OFS_START_TRIGGER, 32'h1);
    n_irq = 0;
    pulse(8'h08, 8'h06);
    chk("filt_irq", 32'(n_irq), 32'h1);
    bus(1'b1, `OFS_STOP_TRIGGER, 32'h1);
    bus(1'b1, `OFS_NOISE_FILTER, 32'h0);
    $display("test event counter done");
    bus(1'b1, `OFS_RELOAD_VALUE, 32'h1);
    bus(1'b1, `OFS_MODE_CONFIG, 32'h1080); // interval, soft start, pin edges
    bus(1'b1, `OFS_OUTPUT_ENABLE, 32'h1);
    bus(1'b1, `OFS_START_TRIGGER, 32'h1);
    settle;
    n_tog = 0;
    pulse(8'h09, 8'h04);
    chk("div_tog", 32'(n_tog), 32'h4);
    $display("test divider done");
    bus(1'b1, `OFS_UNIT_ENABLE, 32'h0);
    settle;
    chk("oe_off", 32'(OE), 32'h0);
    chk("pin_off", 32'(OUT), 32'h0);
    bus(1'b1, `OFS_RELOAD_VALUE, 32'h7);
    rdchk(`OFS_RELOAD_VALUE, 32'h0, "frozen");
    chk("resp", 32'(HRESP), 32'h0);
    chk("hready", 32'(HREADYOUT), 32'h1);
    $display("test unit disable done");
    test_done;
  end
endmodule // tb

// ===== timer_channel.sv
// timer channel: interval timer, event counter, divider, with AHB-Lite register slave
//
// Notes on behaviour
// - start and stop triggers clear themselves
// - interval start sets enable, first count clock loads reload value
// - interval count down, reload, interrupt, toggle
// - stop clears enable, counter holds value
// - output keeps its level after stopping
// - output enable gates counting control of output
// - output value bit sets pin level
// - unit disabled: clock stopped, writes ignored
// - unit disable resets channel and output
// - event start loads reload, awaits edge
// - event count per edge, reload, interrupt
// - interrupt every reload plus one edges
// - new reload value used at next reload
// - divider loads at first edge after start
// - divider counts edges, toggles at zero
// - divider output is input over twice period
// - edge select: falling, rising, both
// - operating clock picks prescaler clock 0 or 1
// - divider period within one operating clock
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "timer_defines.svh"
module timer_channel (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // timer pins
  input wire logic CHAN0_INPUT_PIN,
  output logic CHAN0_OUTPUT_PIN,
  output logic CHAN0_OUTPUT_OE,
  // interrupt pulse
  output logic CHAN_INTERRUPT
);

  timer_pkg::core_t r;
  timer_pkg::core_t next_r;
  timer_pkg::mode_cfg_t cfg;
  logic op_tick;
  logic valid_edge;
  logic count_tick;
  logic wr_now;
  logic start_w;
  logic stop_w;

  // prescaler clock n ticks once every 2^n system clocks
  function automatic logic psc_tick(input logic [15:0] cnt, input logic [3:0] sel);
    logic [15:0] mask;
    mask = 16'(({16'h0000, 16'h0001} << sel) - 32'h0000_0001);
    psc_tick = (cnt & mask) == 16'h0000;
  endfunction

  function automatic logic [31:0] read_reg(input timer_pkg::core_t s, input logic [7:0] a);
    read_reg = 32'h0000_0000;
    unique case (a)
      `OFS_UNIT_ENABLE: read_reg = {31'h0000_0000, s.unit_en};
      `OFS_PRESCALER_SEL: read_reg = {24'h00_0000, s.presc_sel};
      `OFS_MODE_CONFIG: read_reg = {16'h0000, s.mode};
      `OFS_RELOAD_VALUE: read_reg = {16'h0000, s.reload};
      `OFS_COUNTER: read_reg = {16'h0000, s.counter};
      `OFS_START_TRIGGER: read_reg = 32'h0000_0000;
      `OFS_STOP_TRIGGER: read_reg = 32'h0000_0000;
      `OFS_ENABLE_STATUS: read_reg = {31'h0000_0000, s.enable};
      `OFS_OUTPUT_VALUE: read_reg = {31'h0000_0000, s.out_val};
      `OFS_OUTPUT_ENABLE: read_reg = {31'h0000_0000, s.out_en};
      `OFS_OUTPUT_LEVEL: read_reg = {31'h0000_0000, s.out_lvl};
      `OFS_OUTPUT_MODE: read_reg = {31'h0000_0000, s.out_mode};
      `OFS_NOISE_FILTER: read_reg = {31'h0000_0000, s.nf_en};
      default: read_reg = 32'h0000_0000;
    endcase
  endfunction

  assign cfg.cks = r.mode[`MODE_CKS_MSB:`MODE_CKS_LSB];
  assign cfg.ccs = r.mode[`MODE_CCS_BIT];
  assign cfg.cis = r.mode[`MODE_CIS_MSB:`MODE_CIS_LSB];
  assign cfg.md = r.mode[`MODE_MD_MSB:`MODE_MD_LSB];
  assign cfg.md0 = r.mode[`MODE_MD0_BIT];

  // only CK1 on 10B; any other code falls back to CK0 on this channel
  assign op_tick = r.unit_en & ((cfg.cks == `CKS_CK1) ?
    psc_tick(r.presc_cnt, r.presc_sel[`PSC_CK1_MSB:`PSC_CK1_LSB]) :
    psc_tick(r.presc_cnt, r.presc_sel[`PSC_CK0_MSB:`PSC_CK0_LSB]));

  timer_input_stage u_input (
    .CLK(CLK),
    .RST(RST),
    .clear(~r.unit_en),
    .tick(op_tick),
    .filt_en(r.nf_en),
    .edge_sel(cfg.cis),
    .pin(CHAN0_INPUT_PIN),
    .valid_edge(valid_edge)
  );

  // the pin edge counts in event mode and in divider use (ccs set)
  assign count_tick = ((cfg.md == `MD_EVENT) || cfg.ccs) ? valid_edge : op_tick;
  assign wr_now = r.ap_valid & r.ap_write & r.unit_en;
  assign start_w = wr_now & (r.ap_addr == `OFS_START_TRIGGER) & HWDATA[0];
  assign stop_w = wr_now & (r.ap_addr == `OFS_STOP_TRIGGER) & HWDATA[0];

  always_comb begin
    next_r = r;
    next_r.irq = 1'b0;
    next_r.hready = 1'b1;
    next_r.ap_valid = 1'b0;
    // address phase capture; read data is prepared for the data phase
    if (HSEL && HTRANS[1] && HREADY) begin
      next_r.ap_valid = 1'b1;
      next_r.ap_write = HWRITE;
      next_r.ap_addr = HADDR[7:0];
      if (!HWRITE) begin
        next_r.rdata = read_reg(r, HADDR[7:0]);
      end
    end
    // the enable bit itself stays writable, all else is locked while off
    if (r.ap_valid && r.ap_write && r.ap_addr == `OFS_UNIT_ENABLE) begin
      next_r.unit_en = HWDATA[0];
    end
    if (wr_now) begin
      unique case (r.ap_addr)
        `OFS_PRESCALER_SEL: next_r.presc_sel = HWDATA[7:0];
        `OFS_MODE_CONFIG: next_r.mode = HWDATA[15:0];
        `OFS_RELOAD_VALUE: next_r.reload = HWDATA[15:0];
        `OFS_OUTPUT_ENABLE: next_r.out_en = HWDATA[0];
        `OFS_OUTPUT_LEVEL: next_r.out_lvl = HWDATA[0];
        `OFS_OUTPUT_MODE: next_r.out_mode = HWDATA[0];
        `OFS_NOISE_FILTER: next_r.nf_en = HWDATA[0];
        // counting owns the output while enabled, so such writes drop
        `OFS_OUTPUT_VALUE: if (!r.out_en) next_r.out_val = HWDATA[0];
        default: next_r.presc_sel = r.presc_sel;
      endcase
    end
    if (r.unit_en) begin
      next_r.presc_cnt = r.presc_cnt + 16'h0001;
      if (stop_w) begin
        // output register is left alone here
        next_r.enable = 1'b0;
        next_r.state = timer_pkg::ST_IDLE;
      end else if (start_w) begin
        next_r.enable = 1'b1;
        if (cfg.md == `MD_EVENT) begin
          next_r.counter = r.reload;
          next_r.state = timer_pkg::ST_RUN;
        end else begin
          next_r.state = timer_pkg::ST_ARM;
        end
      end else begin
        unique case (r.state)
          timer_pkg::ST_IDLE: next_r.state = timer_pkg::ST_IDLE;
          timer_pkg::ST_ARM: if (count_tick) begin
            // first count clock or first pin edge loads the counter
            next_r.counter = r.reload;
            next_r.state = timer_pkg::ST_RUN;
            if (cfg.md0) begin
              next_r.irq = 1'b1;
              if (r.out_en) next_r.out_val = ~r.out_val;
            end
          end
          timer_pkg::ST_RUN: if (count_tick) begin
            if (r.counter == `COUNT_ZERO) begin
              // reload+1 ticks per period, doubled by the toggle
              next_r.counter = r.reload;
              next_r.irq = 1'b1;
              if (r.out_en) next_r.out_val = ~r.out_val;
            end else begin
              next_r.counter = r.counter - `COUNT_ONE;
            end
          end
        endcase
      end
    end
    // unit off acts as a reset of every channel register
    if (!next_r.unit_en) begin
      next_r.presc_sel = `RST_PRESC;
      next_r.presc_cnt = `RST_WORD16;
      next_r.mode = `RST_WORD16;
      next_r.reload = `RST_WORD16;
      next_r.counter = `RST_WORD16;
      next_r.enable = `RST_BIT;
      next_r.state = timer_pkg::ST_IDLE;
      next_r.out_val = `RST_BIT;
      next_r.out_en = `RST_BIT;
      next_r.out_lvl = `RST_BIT;
      next_r.out_mode = `RST_BIT;
      next_r.nf_en = `RST_BIT;
      next_r.irq = `RST_BIT;
    end
    // pin leaves port mode only while the unit runs
    next_r.pin_oe = next_r.unit_en;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
      r.state <= timer_pkg::ST_IDLE;
      r.hready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign HRDATA = r.rdata;
  assign HREADYOUT = r.hready;
  assign HRESP = 1'b0;
  assign CHAN0_OUTPUT_PIN = r.out_val;
  assign CHAN0_OUTPUT_OE = r.pin_oe;
  assign CHAN_INTERRUPT = r.irq;

  // trigger registers never read back a one
  chk_trigger_reads_zero: assert property (@(posedge CLK) disable iff (RST)
    (HSEL && HTRANS[1] && HREADY && !HWRITE &&
     (HADDR[7:0] == `OFS_START_TRIGGER || HADDR[7:0] == `OFS_STOP_TRIGGER))
    |=> HRDATA == 32'h0000_0000)
    else $error("trigger register read back nonzero");

  chk_stop_halts: assert property (@(posedge CLK) disable iff (RST)
    stop_w |=> !r.enable && r.counter == $past(r.counter))
    else $error("stop did not clear enable or hold count");

  chk_idle_holds: assert property (@(posedge CLK) disable iff (RST)
    (r.state == timer_pkg::ST_IDLE && !start_w && !wr_now && r.unit_en)
    |=> $stable(r.counter) && $stable(r.out_val))
    else $error("stopped channel changed count or output");

  chk_irq_single: assert property (@(posedge CLK) disable iff (RST)
    CHAN_INTERRUPT |=> !CHAN_INTERRUPT)
    else $error("interrupt wider than one cycle");

  chk_zero_reload: assert property (@(posedge CLK) disable iff (RST)
    (r.state == timer_pkg::ST_RUN && count_tick && r.counter == `COUNT_ZERO &&
     !start_w && !stop_w && next_r.unit_en)
    |=> r.counter == $past(r.reload) && CHAN_INTERRUPT)
    else $error("zero count did not reload with interrupt");

  chk_count_down: assert property (@(posedge CLK) disable iff (RST)
    (r.state == timer_pkg::ST_RUN && count_tick && r.counter != `COUNT_ZERO &&
     !start_w && !stop_w && next_r.unit_en)
    |=> r.counter == $past(r.counter) - `COUNT_ONE && !CHAN_INTERRUPT)
    else $error("counter did not decrement by one");

  chk_unit_off: assert property (@(posedge CLK) disable iff (RST)
    !r.unit_en |-> !CHAN0_OUTPUT_PIN && !CHAN0_OUTPUT_OE && !r.enable &&
    r.counter == `COUNT_ZERO)
    else $error("disabled unit not in reset state");

  chk_toggle_gated: assert property (@(posedge CLK) disable iff (RST)
    (!r.out_en && !(wr_now && r.ap_addr == `OFS_OUTPUT_VALUE) && next_r.unit_en)
    |=> $stable(CHAN0_OUTPUT_PIN))
    else $error("output moved with output enable cleared");

  chk_event_start: assert property (@(posedge CLK) disable iff (RST)
    (start_w && cfg.md == `MD_EVENT && !stop_w && next_r.unit_en)
    |=> r.enable && r.counter == $past(r.reload) && r.state == timer_pkg::ST_RUN)
    else $error("event start did not load reload value");

  chk_arm_load: assert property (@(posedge CLK) disable iff (RST)
    (r.state == timer_pkg::ST_ARM && count_tick && !start_w && !stop_w && next_r.unit_en)
    |=> r.counter == $past(r.reload) && CHAN_INTERRUPT == $past(cfg.md0))
    else $error("first count clock did not load as set");

  // with the unit off the prescaler and the count clock stay frozen
  chk_clock_gated: assert property (@(posedge CLK) disable iff (RST)
    !r.unit_en |-> !op_tick && r.presc_cnt == `RST_WORD16)
    else $error("unit clock ran while unit disabled");

  // ignored writes leave the reset values in place
  chk_locked_writes: assert property (@(posedge CLK) disable iff (RST)
    (r.ap_valid && r.ap_write && !r.unit_en && r.ap_addr != `OFS_UNIT_ENABLE)
    |=> !r.unit_en && r.reload == `RST_WORD16 && r.mode == `RST_WORD16)
    else $error("register write landed while unit disabled");

  chk_start_enable: assert property (@(posedge CLK) disable iff (RST)
    (start_w && !stop_w && next_r.unit_en)
    |=> r.enable && r.state != timer_pkg::ST_IDLE)
    else $error("start did not set enable status");

  // with md0 set the first load also toggles an enabled output
  chk_start_toggle: assert property (@(posedge CLK) disable iff (RST)
    (r.state == timer_pkg::ST_ARM && count_tick && cfg.md0 && r.out_en &&
     !start_w && !stop_w && next_r.unit_en)
    |=> CHAN0_OUTPUT_PIN != $past(CHAN0_OUTPUT_PIN))
    else $error("start interrupt came without output toggle");

  chk_zero_toggle: assert property (@(posedge CLK) disable iff (RST)
    (r.state == timer_pkg::ST_RUN && count_tick && r.counter == `COUNT_ZERO && r.out_en &&
     !start_w && !stop_w && next_r.unit_en)
    |=> CHAN0_OUTPUT_PIN != $past(CHAN0_OUTPUT_PIN))
    else $error("zero count did not toggle enabled output");

  // pin edges are the only count clock in event mode
  chk_event_waits: assert property (@(posedge CLK) disable iff (RST)
    (r.state == timer_pkg::ST_RUN && cfg.md == `MD_EVENT && !valid_edge &&
     !start_w && !stop_w && next_r.unit_en)
    |=> $stable(r.counter) && !CHAN_INTERRUPT)
    else $error("event counter moved without a valid edge");

  chk_divider_arm: assert property (@(posedge CLK) disable iff (RST)
    (r.state == timer_pkg::ST_ARM && cfg.ccs && !valid_edge &&
     !start_w && !stop_w && next_r.unit_en)
    |=> r.state == timer_pkg::ST_ARM && !CHAN_INTERRUPT)
    else $error("divider left arm state without an edge");

  // software owns the pin only while output enable is clear
  chk_value_write: assert property (@(posedge CLK) disable iff (RST)
    (wr_now && r.ap_addr == `OFS_OUTPUT_VALUE && !r.out_en)
    |=> CHAN0_OUTPUT_PIN == $past(HWDATA[0]))
    else $error("output value write did not reach the pin");

  chk_value_ignored: assert property (@(posedge CLK) disable iff (RST)
    (wr_now && r.ap_addr == `OFS_OUTPUT_VALUE && r.out_en &&
     r.state == timer_pkg::ST_IDLE)
    |=> $stable(CHAN0_OUTPUT_PIN))
    else $error("output value write landed while output enabled");

  // a stopped channel stays silent until the next start
  chk_idle_quiet: assert property (@(posedge CLK) disable iff (RST)
    (r.state == timer_pkg::ST_IDLE && !start_w && next_r.unit_en)
    |=> !CHAN_INTERRUPT && !r.enable)
    else $error("stopped channel raised interrupt or enable");

  // a pulse always traces back to a count tick of a running channel
  chk_irq_cause: assert property (@(posedge CLK) disable iff (RST)
    CHAN_INTERRUPT |-> $past(count_tick) && $past(r.state) != timer_pkg::ST_IDLE)
    else $error("interrupt without a count tick");

endmodule // timer_channel

// ===== timer_defines.svh
// register offsets, field positions, reset values and timing for the timer channel
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define OFS_UNIT_ENABLE 8'h00
`define OFS_PRESCALER_SEL 8'h04
`define OFS_MODE_CONFIG 8'h08
`define OFS_RELOAD_VALUE 8'h0C
`define OFS_COUNTER 8'h10
`define OFS_START_TRIGGER 8'h14
`define OFS_STOP_TRIGGER 8'h18
`define OFS_ENABLE_STATUS 8'h1C
`define OFS_OUTPUT_VALUE 8'h20
`define OFS_OUTPUT_ENABLE 8'h24
`define OFS_OUTPUT_LEVEL 8'h28
`define OFS_OUTPUT_MODE 8'h2C
`define OFS_NOISE_FILTER 8'h30

`define MODE_CKS_MSB 15
`define MODE_CKS_LSB 14
`define MODE_CCS_BIT 12
`define MODE_STS_MSB 10
`define MODE_STS_LSB 8
`define MODE_CIS_MSB 7
`define MODE_CIS_LSB 6
`define MODE_MD_MSB 3
`define MODE_MD_LSB 1
`define MODE_MD0_BIT 0
`define PSC_CK0_MSB 3
`define PSC_CK0_LSB 0
`define PSC_CK1_MSB 7
`define PSC_CK1_LSB 4

`define MD_INTERVAL 3'h0
`define MD_EVENT 3'h3
`define CKS_CK0 2'h0
`define CKS_CK1 2'h2
`define CIS_FALL 2'h0
`define CIS_RISE 2'h1
`define CIS_BOTH 2'h2

`define RST_WORD16 16'h0000
`define RST_PRESC 8'h00
`define RST_BIT 1'h0
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define FILTER_CYCLES 2

`endif

// ===== timer_edge_source.sv
// edge source model driving the timer input pin
`timescale 1ns/1ps
module timer_edge_source (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // request: pin transitions and cycles per level
  input wire logic go,
  input wire logic [7:0] n_edge,
  input wire logic [7:0] half,
  // pin side
  output logic pin,
  output logic busy
);
  logic [7:0] left;
  logic [7:0] cnt;
  // half of 2 or more keeps each level for at least two operating ticks; larger half answers slowly
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin <= 1'b0;
      left <= 8'h00;
      cnt <= 8'h00;
    end else if (left == 8'h00) begin
      if (go) begin
        left <= n_edge;
        cnt <= half;
      end
    end else if (cnt <= 8'h01) begin
      pin <= ~pin;
      left <= left - 8'h01;
      cnt <= half;
    end else begin
      cnt <= cnt - 8'h01;
    end
  end
  assign busy = (left != 8'h00);
endmodule // timer_edge_source

// ===== timer_input_stage.sv
// input pin sampling, optional noise filter and valid edge detection
`timescale 1ns/1ps
`include "timer_defines.svh"
module timer_input_stage (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // control
  input wire logic clear,
  input wire logic tick,
  input wire logic filt_en,
  input wire logic [1:0] edge_sel,
  // pin and result
  input wire logic pin,
  output logic valid_edge
);

  timer_pkg::edge_state_t r;
  timer_pkg::edge_state_t next_r;
  logic lvl;

  always_comb begin
    next_r = r;
    next_r.valid_edge = 1'b0;
    lvl = filt_en ? r.filt[0] : r.sync[1];
    if (clear) begin
      next_r = '0;
    end else if (tick) begin
      // sampled on the operating clock only, so edges carry one period of error
      next_r.sync = {r.sync[0], pin};
      // filter passes a level only once it held for two samples
      if (r.sync[1] == r.filt[1]) begin
        next_r.filt[0] = r.sync[1];
      end
      next_r.filt[1] = r.sync[1];
      next_r.last = lvl;
      unique case (edge_sel)
        `CIS_FALL: next_r.valid_edge = r.last & ~lvl;
        `CIS_RISE: next_r.valid_edge = ~r.last & lvl;
        `CIS_BOTH: next_r.valid_edge = r.last ^ lvl;
        default: next_r.valid_edge = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign valid_edge = r.valid_edge;

endmodule // timer_input_stage

// ===== timer_pkg.sv
// types shared by the timer channel and its input stage
package timer_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM = 3'b010,
    ST_RUN = 3'b100
  } chan_state_t;

  typedef struct packed {
    logic [1:0] cks;
    logic ccs;
    logic [1:0] cis;
    logic [2:0] md;
    logic md0;
  } mode_cfg_t;

  typedef struct packed {
    logic [1:0] sync;
    logic [1:0] filt;
    logic last;
    logic valid_edge;
  } edge_state_t;

  typedef struct packed {
    logic unit_en;
    logic [7:0] presc_sel;
    logic [15:0] presc_cnt;
    logic [15:0] mode;
    logic [15:0] reload;
    logic [15:0] counter;
    logic enable;
    chan_state_t state;
    logic out_val;
    logic out_en;
    logic out_lvl;
    logic out_mode;
    logic nf_en;
    logic irq;
    logic pin_oe;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic hready;
  } core_t;

endpackage
